/* File: shared/memctl_ops_pkg.sv */
// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
package memctl_ops_pkg;
	localparam int INS_W = 40; // one instruction word
	localparam int WORD_W = 40; // one processor word: cdr, tag, data
	localparam int ADDR_W = 38; // wide enough for the long immediate
	localparam int TAG_W = 6; // data type tag of a word
	localparam int REG_AW = 6; // processor register number
	localparam int IMM12_W = 12; // short immediate

	// ------------------------------------------------------------------
	// instruction field positions
	// ------------------------------------------------------------------
	localparam int FMT_HI = 37;
	localparam int FMT_LO = 35;
	localparam int OPC_HI = 34;
	localparam int OPC_LO = 29;
	localparam int SRC1_HI = 28;
	localparam int SRC1_LO = 23;
	localparam int SRC2_HI = 22; // also destination in short immediate read
	localparam int SRC2_LO = 17;
	localparam int TYPE_HI = 16;
	localparam int TYPE_LO = 12;
	localparam int DEST_HI = 5;
	localparam int DEST_LO = 0;
	localparam int IMM12_HI = 11;
	localparam int IMM38_HI = 37; // long immediate in the second word

	// ------------------------------------------------------------------
	// word field positions
	// ------------------------------------------------------------------
	localparam int TAG_HI = 37;
	localparam int TAG_LO = 32;
	localparam int DATA_HI = 31;

	// ------------------------------------------------------------------
	// encodings and reset values
	// ------------------------------------------------------------------
	localparam logic [5:0] OPC_MC_READ = 6'h37; // octal 67
	localparam logic [5:0] OPC_MC_WRITE = 6'h27; // octal 47
	localparam logic [2:0] FMT_RR = 3'h6; // two_register_form
	localparam logic [2:0] FMT_RIS = 3'h7; // short_immediate_form
	localparam logic [2:0] FMT_RIL = 3'h5; // long_immediate_form
	localparam logic [TAG_W-1:0] FIXNUM_TAG_DEFAULT = 6'h08; // plain default
	localparam logic RST_READY = 1'b1; // ready to take a word after reset

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_IMMED = 5'h02,
		ST_FETCH = 5'h04,
		ST_CHECK = 5'h08,
		ST_WAIT = 5'h10
	} op_state_t;
endpackage

/* File: design/proc_regfile.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// processor register file, two registered read ports
// ----------------------------------------------------------------------
module proc_regfile #(
	parameter int AW = 6,
	parameter int W = 40
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [AW-1:0] rd1_addr,
	input wire logic [AW-1:0] rd2_addr,
	output logic [W-1:0] rd1_data,
	output logic [W-1:0] rd2_data,
	input wire logic load_en,
	input wire logic [AW-1:0] load_addr,
	input wire logic [W-1:0] load_data,
	input wire logic wb_en,
	input wire logic [AW-1:0] wb_addr,
	input wire logic [W-1:0] wb_data
);
	logic [W-1:0] mem [2**AW]; // storage, no reset needed

	// write: the instruction write-back wins over a core load
	always_ff @(posedge mclk) begin
		if (load_en && !(wb_en && wb_addr == load_addr)) begin
			mem[load_addr] <= load_data;
		end
		if (wb_en) begin
			mem[wb_addr] <= wb_data;
		end
	end

	// read data leave through registers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rd1_data <= '0;
			rd2_data <= '0;
		end else begin
			rd1_data <= mem[rd1_addr];
			rd2_data <= mem[rd2_addr];
		end
	end
endmodule

/* File: design/memctl_reg_ops.sv */
`timescale 1ns/1ps
// How it works
// - opcode 67 two-register read: src1+src2 address
// - read immediates: 12-bit signed, 38-bit long
// - read checks src1 type, RR src2 fixnum
// - read returns addressed control register; no traps
// - opcode 47 two-register write: src1+mar, src2
// - short write: src1+signed imm12, store src2
// - long write: imm38+src1, store src2
// - write checks only src1 type
// - address goes to memory control, not cache
// - data moves over shared internal bus
module memctl_reg_ops import memctl_ops_pkg::*; #(
	parameter logic [TAG_W-1:0] FIXNUM_TAG = FIXNUM_TAG_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ins_valid,
	input wire logic [INS_W-1:0] ins_word,
	output logic ins_ready,
	input wire logic [ADDR_W-1:0] mar,
	input wire logic load_en,
	input wire logic [REG_AW-1:0] load_addr,
	input wire logic [WORD_W-1:0] load_data,
	output logic mc_req,
	output logic mc_write,
	output logic [ADDR_W-1:0] mc_addr,
	output logic [WORD_W-1:0] internal_shared_data_bus_out,
	input wire logic [WORD_W-1:0] internal_shared_data_bus_in,
	input wire logic mc_ack,
	output logic type_trap,
	output logic op_done
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		op_state_t state; // sequencer
		logic [INS_W-1:0] ins; // latched first word
		logic [ADDR_W-1:0] imm; // latched long immediate
		logic ready; // may take a word
		logic req; // request to memory control
		logic wr; // request is a write
		logic [ADDR_W-1:0] addr; // control register address
		logic [WORD_W-1:0] bus_out; // write data
		logic trap; // type trap pulse
		logic done; // finished pulse
		logic rf_we; // write-back strobe
		logic [REG_AW-1:0] rf_wa; // write-back register
		logic [WORD_W-1:0] rf_wd; // write-back data
	} ops_t;

	ops_t cur; // registered state
	ops_t next_cur; // next state

	logic [WORD_W-1:0] rd1; // source1 word
	logic [WORD_W-1:0] rd2; // source2 word
	logic is_read; // opcode of the read op
	logic is_write; // opcode of the write op
	logic [2:0] fmt; // format bits
	logic [TAG_W-1:0] want_tag; // type field widened
	logic tag_ok; // all source checks pass
	logic [ADDR_W-1:0] offset; // second adder input
	logic [ADDR_W-1:0] sum; // shared adder output

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// one adder serves every form, as for loads and stores
	function automatic logic [ADDR_W-1:0] add_addr(input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] b);
		add_addr = a + b;
	endfunction

	// operand data field widened to an address
	function automatic logic [ADDR_W-1:0] word_addr(input logic [WORD_W-1:0] w);
		word_addr = {{(ADDR_W-DATA_HI-1){1'b0}}, w[DATA_HI:0]};
	endfunction

	// short immediate read puts its destination where source2 sits
	function automatic logic [REG_AW-1:0] dest_of(input logic [INS_W-1:0] i);
		if (i[FMT_HI:FMT_LO] == FMT_RIS) begin
			dest_of = i[SRC2_HI:SRC2_LO];
		end else begin
			dest_of = i[DEST_HI:DEST_LO];
		end
	endfunction

	// ------------------------------------------------------------------
	// source registers
	// ------------------------------------------------------------------
	proc_regfile #(
		.AW(REG_AW),
		.W(WORD_W)
	) u_regs (
		.mclk(mclk),
		.rst_b(rst_b),
		.rd1_addr(cur.ins[SRC1_HI:SRC1_LO]),
		.rd2_addr(cur.ins[SRC2_HI:SRC2_LO]),
		.rd1_data(rd1),
		.rd2_data(rd2),
		.load_en(load_en),
		.load_addr(load_addr),
		.load_data(load_data),
		.wb_en(cur.rf_we),
		.wb_addr(cur.rf_wa),
		.wb_data(cur.rf_wd)
	);

	// ------------------------------------------------------------------
	// decode, checks and address
	// ------------------------------------------------------------------
	always_comb begin
		fmt = cur.ins[FMT_HI:FMT_LO];
		is_read = cur.ins[OPC_HI:OPC_LO] == OPC_MC_READ;
		is_write = cur.ins[OPC_HI:OPC_LO] == OPC_MC_WRITE;
		want_tag = {1'b0, cur.ins[TYPE_HI:TYPE_LO]};
		// source1 always checked; source2 only for the RR read
		tag_ok = rd1[TAG_HI:TAG_LO] == want_tag;
		if (is_read && fmt == FMT_RR && rd2[TAG_HI:TAG_LO] != FIXNUM_TAG) begin
			tag_ok = 1'b0;
		end
		// second adder input per form
		if (fmt == FMT_RR && is_read) begin
			offset = word_addr(rd2);
		end else if (fmt == FMT_RR) begin
			offset = mar;
		end else if (fmt == FMT_RIS) begin
			offset = {{(ADDR_W-IMM12_W){cur.ins[IMM12_HI]}}, cur.ins[IMM12_HI:0]};
		end else begin
			offset = cur.imm;
		end
		sum = add_addr(word_addr(rd1), offset);
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.trap = 1'b0;
		next_cur.done = 1'b0;
		next_cur.rf_we = 1'b0;
		case (cur.state)
			ST_IDLE: begin
				if (ins_valid) begin
					next_cur.ins = ins_word;
					// long form needs its immediate word first
					if (ins_word[FMT_HI:FMT_LO] == FMT_RIL) begin
						next_cur.state = ST_IMMED;
					end else begin
						next_cur.ready = 1'b0;
						next_cur.state = ST_FETCH;
					end
				end
			end
			ST_IMMED: begin
				if (ins_valid) begin
					next_cur.imm = ins_word[IMM38_HI:0];
					next_cur.ready = 1'b0;
					next_cur.state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				// register file read is under way
				next_cur.state = ST_CHECK;
			end
			ST_CHECK: begin
				next_cur.state = ST_IDLE;
				next_cur.ready = 1'b1;
				if (!(is_read || is_write) || !(fmt == FMT_RR || fmt == FMT_RIS
						|| fmt == FMT_RIL)) begin
					// not one of ours: finishes with a done pulse, no request and no trap
					next_cur.done = 1'b1;
				end else if (!tag_ok) begin
					next_cur.trap = 1'b1;
				end else begin
					// address is control information, not a cache address
					next_cur.req = 1'b1;
					next_cur.wr = is_write;
					next_cur.addr = sum;
					next_cur.bus_out = is_write ? rd2 : '0;
					next_cur.ready = 1'b0;
					next_cur.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (mc_ack) begin
					next_cur.req = 1'b0;
					next_cur.wr = 1'b0;
					next_cur.done = 1'b1;
					next_cur.ready = 1'b1;
					next_cur.state = ST_IDLE;
					// read data come back over the shared bus, no trap
					next_cur.rf_we = !cur.wr;
					next_cur.rf_wa = dest_of(cur.ins);
					next_cur.rf_wd = internal_shared_data_bus_in;
				end
			end
			default: begin
				next_cur.state = ST_IDLE;
				next_cur.ready = RST_READY;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cur <= '0;
			cur.state <= ST_IDLE;
			cur.ready <= RST_READY;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state
	assign ins_ready = cur.ready;
	assign mc_req = cur.req;
	assign mc_write = cur.wr;
	assign mc_addr = cur.addr;
	assign internal_shared_data_bus_out = cur.bus_out;
	assign type_trap = cur.trap;
	assign op_done = cur.done;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	logic go; // check stage issues a request
	assign go = cur.state == ST_CHECK && tag_ok && (is_read || is_write)
		&& (fmt == FMT_RR || fmt == FMT_RIS || fmt == FMT_RIL);

	req_hold_a: assert property (mc_req && !mc_ack |=> mc_req && $stable(mc_addr))
		else $error("request dropped before acknowledge");
	rr_read_addr_a: assert property (go && is_read && fmt == FMT_RR |=>
			mc_req && !mc_write && mc_addr == $past(word_addr(rd1)) + $past(word_addr(rd2)))
		else $error("two-register read address wrong");
	ril_addr_a: assert property (go && fmt == FMT_RIL |=>
			mc_addr == $past(word_addr(rd1)) + $past(cur.imm))
		else $error("long immediate address wrong");
	fixnum_trap_a: assert property (cur.state == ST_CHECK && is_read && fmt == FMT_RR
			&& rd2[TAG_HI:TAG_LO] != FIXNUM_TAG |=> type_trap && !mc_req)
		else $error("source2 type not trapped");
	read_wb_a: assert property (mc_req && mc_ack && !mc_write |=>
			op_done && !type_trap && cur.rf_we && cur.rf_wd == $past(internal_shared_data_bus_in))
		else $error("read data not written back");
	rr_write_mar_a: assert property (go && is_write && fmt == FMT_RR |=>
			mc_write && mc_addr == $past(word_addr(rd1)) + $past(mar))
		else $error("two-register write address wrong");
	ris_write_a: assert property (go && is_write && fmt == FMT_RIS |=>
			internal_shared_data_bus_out == $past(rd2)
			&& mc_addr == $past(word_addr(rd1)) + ADDR_W'($signed($past(cur.ins[IMM12_HI:0]))))
		else $error("short immediate write wrong");
	ril_write_data_a: assert property (go && is_write && fmt == FMT_RIL |=>
			mc_write ##0 internal_shared_data_bus_out == $past(rd2))
		else $error("long immediate write data wrong");
	write_tag_only_a: assert property (cur.state == ST_CHECK && is_write
			&& rd1[TAG_HI:TAG_LO] == want_tag && fmt != 3'h0 && fmt == FMT_RR |=> !type_trap)
		else $error("write trapped on other than source1");
	bus_quiet_a: assert property (mc_req && !mc_write |-> internal_shared_data_bus_out == '0)
		else $error("read drives write data");

	read_done_c: cover property (mc_req && !mc_write && mc_ack ##1 op_done);
	write_ril_c: cover property (cur.state == ST_IMMED ##[1:4] mc_req && mc_write);
	trap_c: cover property (type_trap);
	stall_c: cover property (mc_req && !mc_ack [*3] ##1 mc_ack);
endmodule

/* File: testbench/memctl_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// memory control side: sixteen control registers, ack after a delay
// ----------------------------------------------------------------------
module memctl_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic mc_req,
	input wire logic mc_write,
	input wire logic [37:0] mc_addr,
	input wire logic [39:0] wr_data,
	input wire logic [2:0] ack_delay,
	output logic mc_ack,
	output logic [39:0] rd_data
);
	logic [39:0] regs [16]; // control registers, low address bits decode
	logic [2:0] cnt; // wait cycles spent on this request

	// answer each request once; the bus toggles when not driven
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mc_ack <= 1'b0;
			cnt <= 3'h0;
			rd_data <= 40'h0;
			for (int i = 0; i < 16; i++) begin
				regs[i] <= 40'h00a5000000 | 40'(i);
			end
		end else begin
			// released bus: never holds the last value
			rd_data <= ~rd_data;
			mc_ack <= 1'b0;
			if (mc_req && !mc_ack) begin
				if (cnt == ack_delay) begin
					mc_ack <= 1'b1;
					cnt <= 3'h0;
					// address decoded as a register select, not memory
					if (mc_write) begin
						regs[mc_addr[3:0]] <= wr_data;
					end else begin
						rd_data <= regs[mc_addr[3:0]];
					end
				end else begin
					cnt <= cnt + 3'h1;
				end
			end
		end
	end
endmodule

/* File: testbench/tb_mem_ctrl_reg_access_ops.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// bench for the control register read and write instructions
// ----------------------------------------------------------------------
module tb_mem_ctrl_reg_access_ops;
	import memctl_ops_pkg::*;
	logic mclk, rst_b, ins_valid, ins_ready, load_en, mc_req, mc_write, mc_ack;
	logic type_trap, op_done;
	logic [39:0] ins_word, load_data, bus_out, bus_in;
	logic [37:0] mar, mc_addr;
	logic [5:0] load_addr;
	logic [2:0] ack_delay; // slow or prompt far side
	int miscompares = 0;
	int comparisons = 0;
	localparam logic [5:0] FX = FIXNUM_TAG_DEFAULT;
	localparam logic [4:0] T = FX[4:0]; // type field naming fixnum

	memctl_reg_ops DUT (.mclk(mclk), .rst_b(rst_b), .ins_valid(ins_valid),
		.ins_word(ins_word), .ins_ready(ins_ready), .mar(mar), .load_en(load_en),
		.load_addr(load_addr), .load_data(load_data), .mc_req(mc_req),
		.mc_write(mc_write), .mc_addr(mc_addr), .internal_shared_data_bus_out(bus_out),
		.internal_shared_data_bus_in(bus_in), .mc_ack(mc_ack), .type_trap(type_trap),
		.op_done(op_done));
	memctl_model MC (.mclk(mclk), .rst_b(rst_b), .mc_req(mc_req), .mc_write(mc_write),
		.mc_addr(mc_addr), .wr_data(bus_out), .ack_delay(ack_delay), .mc_ack(mc_ack),
		.rd_data(bus_in));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [39:0] wd(input logic [5:0] tag, input logic [31:0] d);
		return {2'b00, tag, d};
	endfunction
	function automatic logic [39:0] mval(input int idx);
		return 40'h00a5000000 | 40'(idx);
	endfunction
	function automatic logic [39:0] ins(input logic [2:0] f, input logic [5:0] op,
		input logic [5:0] s1, input logic [5:0] s2, input logic [4:0] t,
		input logic [11:0] im);
		return {2'b00, f, op, s1, s2, t, im};
	endfunction

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// register load, one pulse per word
	task automatic ld(input logic [5:0] a, input logic [39:0] d);
		@(posedge mclk);
		load_en <= 1'b1;
		load_addr <= a;
		load_data <= d;
		@(posedge mclk);
		load_en <= 1'b0;
	endtask

	// one instruction, then judge request or trap
	task automatic run(input logic [39:0] w, input logic lng, input logic [37:0] im,
		input logic etrap, input logic ewr, input logic [37:0] eaddr,
		input logic [39:0] edata);
		logic rq;
		logic tr;
		logic dn;
		int n;
		rq = 1'b0;
		tr = 1'b0;
		dn = 1'b0;
		n = 0;
		while (ins_ready !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		ins_valid <= 1'b1;
		ins_word <= w;
		// long form: immediate word follows back to back
		if (lng) begin
			@(posedge mclk);
			ins_word <= {2'b00, im};
		end
		@(posedge mclk);
		ins_valid <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			#1;
			if (type_trap === 1'b1) tr = 1'b1;
			if (mc_req === 1'b1 && !rq) begin
				rq = 1'b1;
				chk(40'(mc_write), 40'(ewr));
				chk(40'(mc_addr), 40'(eaddr));
				if (ewr) chk(bus_out, edata);
			end
			// finish pulse only for an instruction that was not trapped
			if (op_done === 1'b1) dn = 1'b1;
			if (op_done === 1'b1 || type_trap === 1'b1) break;
		end
		chk(40'(tr), 40'(etrap));
		chk(40'(rq), 40'(!etrap));
		chk(40'(dn), 40'(!etrap));
		chk(40'(ins_ready), 40'h1);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_two_reg;
		ack_delay <= 3'h5;
		run(ins(FMT_RR, OPC_MC_READ, 1, 2, T, 12'd10), 0, 0, 0, 0, 38'h5, 0);
		mar <= 38'h7;
		run(ins(FMT_RR, OPC_MC_WRITE, 4, 10, T, 0), 0, 0, 0, 1, 38'h7, mval(5));
		$display("test two register forms done");
	endtask

	// negative short immediate, long immediate with top bits set
	task automatic t_immed;
		ack_delay <= 3'h0;
		run(ins(FMT_RIS, OPC_MC_READ, 5, 11, T, 12'hffc), 0, 0, 0, 0, 38'h10, 0);
		run(ins(FMT_RIS, OPC_MC_WRITE, 4, 11, T, 12'h003), 0, 0, 0, 1, 38'h3, mval(0));
		run(ins(FMT_RIL, OPC_MC_READ, 4, 0, T, 12'd12), 1, 38'h3f00000003, 0, 0,
			38'h3f00000003, 0);
		run(ins(FMT_RIL, OPC_MC_WRITE, 5, 12, T, 0), 1, 38'h1, 0, 1, 38'h15, mval(0));
		$display("test immediate forms done");
	endtask

	// source type checks differ between read and write
	task automatic t_types;
		ack_delay <= 3'h2;
		mar <= 38'h1;
		run(ins(FMT_RR, OPC_MC_READ, 1, 3, T, 12'd13), 0, 0, 1, 0, 0, 0);
		run(ins(FMT_RIS, OPC_MC_READ, 3, 13, T, 12'h001), 0, 0, 1, 0, 0, 0);
		run(ins(FMT_RR, OPC_MC_READ, 3, 2, 5'h01, 12'd13), 0, 0, 0, 0, 38'h6, 0);
		run(ins(FMT_RR, OPC_MC_WRITE, 4, 3, T, 0), 0, 0, 0, 1, 38'h1, wd(6'h01, 3));
		run(ins(FMT_RIS, OPC_MC_WRITE, 3, 4, T, 12'h002), 0, 0, 1, 0, 0, 0);
		$display("test type checks done");
	endtask

	// foreign opcode: finishes quietly, no request and no trap
	task automatic t_foreign;
		logic seen_rq;
		logic seen_dn;
		seen_rq = 1'b0;
		seen_dn = 1'b0;
		while (ins_ready !== 1'b1) begin
			@(posedge mclk);
		end
		@(posedge mclk);
		ins_valid <= 1'b1;
		ins_word <= ins(FMT_RR, 6'h01, 1, 2, T, 12'd14);
		@(posedge mclk);
		ins_valid <= 1'b0;
		repeat (6) begin
			@(posedge mclk);
			#1;
			if (mc_req === 1'b1 || type_trap === 1'b1) seen_rq = 1'b1;
			if (op_done === 1'b1) seen_dn = 1'b1;
		end
		chk(40'(seen_rq), 40'h0);
		chk(40'(seen_dn), 40'h1);
		chk(40'(ins_ready), 40'h1);
		$display("test foreign opcode done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// clock, reset, sequence, watchdog
	// ------------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		rst_b = 1'b0;
		ins_valid = 1'b0;
		ins_word = 40'h0;
		load_en = 1'b0;
		load_addr = 6'h0;
		load_data = 40'h0;
		mar = 38'h0;
		ack_delay = 3'h0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		ld(1, wd(FX, 2));
		ld(2, wd(FX, 3));
		ld(3, wd(6'h01, 3));
		ld(4, wd(FX, 0));
		ld(5, wd(FX, 20));
		t_two_reg();
		t_immed();
		t_types();
		t_foreign();
		report_and_stop();
	end

	// hang guard, far beyond the hundred or so cycles needed
	initial begin
		#50000;
		miscompares++;
		report_and_stop();
	end
endmodule
